// [logic/accel_mode_pkg.sv]
// constants shared by the accelerometer operating-mode controller
// Summary of operation
// - the device never drives the serial clock line low; no clock stretching
// - spikes up to 50 ns on clock and data inputs are filtered out
// - output codes scale 1024, 512 or 256 counts per g by range
// - output data from offset 0x00 are two's complement, zero mid-range
// - self-test output is sensed acceleration plus test stimulus, range scaled
// - powered off: all logic inactive, no bus participation
// - active bit clear: standby, registers reachable, sensing and sample clocks stopped
// - active bit set: active mode, sampling and processing run
// - each standby to active entry returns data registers to reset values
// - wake and sleep are sub-states of active, run only with active set
package accel_mode_pkg;
	localparam logic [7:0] OFS_OUT_X     = 8'h00;
	localparam logic [7:0] OFS_OUT_Y     = 8'h04;
	localparam logic [7:0] OFS_OUT_Z     = 8'h08;
	localparam logic [7:0] OFS_CTRL      = 8'h0C;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] OFS_SMP_COUNT = 8'h14;

	localparam int CTRL_ACTIVE_BIT = 0;
	localparam int CTRL_RANGE_LSB  = 1;
	localparam int CTRL_SELFT_BIT  = 3;
	localparam int CTRL_SLEEP_BIT  = 4;
	localparam int CTRL_WIDTH      = 5;
	localparam int STAT_MODE_LSB   = 0;
	localparam int STAT_DRDY_BIT   = 2;

	localparam logic [4:0]  CTRL_RESET  = 5'h00;
	localparam logic [11:0] DATA_RESET  = 12'h000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	localparam logic [1:0] RANGE_2G = 2'h0;
	localparam logic [1:0] RANGE_4G = 2'h1;
	localparam logic [1:0] RANGE_8G = 2'h2;

	localparam int SENS_2G = 1024;
	localparam int SENS_4G = 512;
	localparam int SENS_8G = 256;
	localparam int SHIFT_4G = $clog2(SENS_2G / SENS_4G);
	localparam int SHIFT_8G = $clog2(SENS_2G / SENS_8G);

	localparam int CLK_PERIOD_NS = 50;
	localparam int GLITCH_NS     = 50;
	localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic signed [11:0] CODE_MAX = 12'sh7ff;
	localparam logic signed [11:0] CODE_MIN = -12'sh800;

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_STANDBY,
		MODE_WAKE,
		MODE_SLEEP
	} op_mode_t;
endpackage

// [logic/spike_filter.sv]
// input spike filter for the serial bus lines
`timescale 1ns/1ps
`default_nettype none
module spike_filter
	import accel_mode_pkg::*;
#(
	parameter int WIDTH = 2
) (
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] line_in,
	output var  logic [WIDTH-1:0] line_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_line
			logic [3:0] cnt_ff;
			logic       out_ff;
			// a new level must persist beyond the spike width before it is passed on
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					cnt_ff <= 4'h0;
					out_ff <= 1'b1;
				end else if (line_in[i] == out_ff) begin
					cnt_ff <= 4'h0;
				end else if (cnt_ff == 4'(GLITCH_CYC)) begin
					cnt_ff <= 4'h0;
					out_ff <= line_in[i];
				end else begin
					cnt_ff <= cnt_ff + 4'h1;
				end
			end
			assign line_out[i] = out_ff;
		end
	endgenerate
endmodule
`default_nettype wire

// [logic/accel_mode_ctrl.sv]
// operating-mode controller: power states, sampling, output scaling, register port
`timescale 1ns/1ps
`default_nettype none
module accel_mode_ctrl
	import accel_mode_pkg::*;
#(
	parameter int unsigned      WAKE_DIV      = 25000,
	parameter int unsigned      SLEEP_DIV     = 400000,
	parameter int unsigned      SLEEP_SAMPLES = 16,
	parameter logic signed [15:0] ST_STIM     = 16'sh00c0
) (
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	input  wire logic               power_good,
	input  wire logic [7:0]         bus_addr,
	input  wire logic [31:0]        bus_wdata,
	input  wire logic               bus_wr,
	input  wire logic               bus_rd,
	output var  logic [31:0]        bus_rdata,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output var  logic               scl_filt,
	output var  logic               sda_filt,
	output var  logic               scl_out,
	output var  logic               scl_oe,
	input  wire logic signed [15:0] accel_x,
	input  wire logic signed [15:0] accel_y,
	input  wire logic signed [15:0] accel_z,
	input  wire logic               motion_evt,
	output var  logic               sense_en,
	output var  logic               selftest_drive,
	output var  logic               sample_tick,
	output var  op_mode_t           op_mode
);
	logic                    rst_all;
	logic [CTRL_WIDTH-1:0]   ctrl_ff;
	op_mode_t                mode_ff;
	op_mode_t                nxt_mode;
	logic [31:0]             div_cnt_ff;
	logic                    tick_ff;
	logic [15:0]             smp_cnt_ff;
	logic [15:0]             idle_cnt_ff;
	logic                    drdy_ff;
	logic [31:0]             rdata_ff;
	logic                    sense_ff;
	logic                    st_ff;
	logic                    scl_oe_ff;
	logic [1:0]              filt_out;
	logic                    act_entry;
	logic                    running;
	logic [1:0]              range;
	logic signed [15:0]      accel_in [3];
	logic signed [11:0]      data_ff  [3];
	logic signed [11:0]      nxt_data [3];

	// an unpowered device holds every flop in reset and ignores the bus
	assign rst_all   = sys_rst | ~power_good;
	assign range     = ctrl_ff[CTRL_RANGE_LSB +: 2];
	assign running   = (mode_ff == MODE_WAKE) || (mode_ff == MODE_SLEEP);
	assign act_entry = ctrl_ff[CTRL_ACTIVE_BIT] && (mode_ff == MODE_STANDBY);
	assign accel_in[0] = accel_x;
	assign accel_in[1] = accel_y;
	assign accel_in[2] = accel_z;

	spike_filter #(
		.WIDTH (2)
	) u_filter (
		.mclk     (mclk),
		.sys_rst  (rst_all),
		.line_in  ({sda_in, scl_in}),
		.line_out (filt_out)
	);

	assign scl_filt = filt_out[0];
	assign sda_filt = filt_out[1];

	// clock line is never pulled low, so the master owns the low phase
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			scl_oe_ff <= 1'b0;
		end else begin
			scl_oe_ff <= 1'b0;
		end
	end
	assign scl_oe  = scl_oe_ff;
	assign scl_out = 1'b0;

	always_ff @(posedge mclk) begin
		if (rst_all) begin
			ctrl_ff <= CTRL_RESET;
		end else if (bus_wr && bus_addr == OFS_CTRL) begin
			ctrl_ff <= bus_wdata[CTRL_WIDTH-1:0];
		end
	end

	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			MODE_OFF: begin
				nxt_mode = MODE_STANDBY;
			end
			MODE_STANDBY: begin
				if (ctrl_ff[CTRL_ACTIVE_BIT]) begin
					nxt_mode = MODE_WAKE;
				end
			end
			MODE_WAKE: begin
				if (!ctrl_ff[CTRL_ACTIVE_BIT]) begin
					nxt_mode = MODE_STANDBY;
				end else if (ctrl_ff[CTRL_SLEEP_BIT] && idle_cnt_ff >= 16'(SLEEP_SAMPLES)) begin
					nxt_mode = MODE_SLEEP;
				end
			end
			MODE_SLEEP: begin
				if (!ctrl_ff[CTRL_ACTIVE_BIT]) begin
					nxt_mode = MODE_STANDBY;
				end else if (motion_evt || !ctrl_ff[CTRL_SLEEP_BIT]) begin
					nxt_mode = MODE_WAKE;
				end
			end
			default: begin
				nxt_mode = MODE_STANDBY;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst_all) begin
			mode_ff <= MODE_OFF;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// sample clock stops whenever the device is not active
	always_ff @(posedge mclk) begin
		if (rst_all || !running || !ctrl_ff[CTRL_ACTIVE_BIT]) begin
			div_cnt_ff <= 32'h0000_0000;
			tick_ff    <= 1'b0;
		end else if (div_cnt_ff >= ((mode_ff == MODE_SLEEP) ? SLEEP_DIV : WAKE_DIV) - 32'h1) begin
			div_cnt_ff <= 32'h0000_0000;
			tick_ff    <= 1'b1;
		end else begin
			div_cnt_ff <= div_cnt_ff + 32'h1;
			tick_ff    <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst_all) begin
			sense_ff <= 1'b0;
			st_ff    <= 1'b0;
		end else begin
			sense_ff <= running && ctrl_ff[CTRL_ACTIVE_BIT];
			st_ff    <= running && ctrl_ff[CTRL_ACTIVE_BIT] && ctrl_ff[CTRL_SELFT_BIT];
		end
	end

	// wider intermediate keeps stimulus plus acceleration from wrapping before saturation
	genvar ax;
	generate
		for (ax = 0; ax < 3; ax++) begin : g_axis
			logic signed [16:0] sum;
			logic signed [16:0] scaled;
			always_comb begin
				sum = 17'(accel_in[ax]) + (ctrl_ff[CTRL_SELFT_BIT] ? 17'(ST_STIM) : 17'sh0_0000);
				case (range)
					RANGE_2G: scaled = sum;
					RANGE_4G: scaled = sum >>> SHIFT_4G;
					default:  scaled = sum >>> SHIFT_8G;
				endcase
				if (scaled > 17'(CODE_MAX)) begin
					nxt_data[ax] = CODE_MAX;
				end else if (scaled < 17'(CODE_MIN)) begin
					nxt_data[ax] = CODE_MIN;
				end else begin
					nxt_data[ax] = scaled[11:0];
				end
			end
			always_ff @(posedge mclk) begin
				if (rst_all || act_entry) begin
					data_ff[ax] <= DATA_RESET;
				end else if (tick_ff) begin
					data_ff[ax] <= nxt_data[ax];
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst_all || act_entry) begin
			smp_cnt_ff <= COUNT_RESET;
		end else if (tick_ff) begin
			smp_cnt_ff <= smp_cnt_ff + 16'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst_all || act_entry || mode_ff != MODE_WAKE || motion_evt) begin
			idle_cnt_ff <= COUNT_RESET;
		end else if (tick_ff && idle_cnt_ff != 16'hffff) begin
			idle_cnt_ff <= idle_cnt_ff + 16'h1;
		end
	end

	// a new sample in the cycle of the clearing read keeps the flag set
	always_ff @(posedge mclk) begin
		if (rst_all || act_entry) begin
			drdy_ff <= 1'b0;
		end else if (tick_ff) begin
			drdy_ff <= 1'b1;
		end else if (bus_rd && bus_addr == OFS_OUT_X) begin
			drdy_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst_all) begin
			rdata_ff <= 32'h0000_0000;
		end else if (bus_rd) begin
			case (bus_addr)
				OFS_OUT_X:     rdata_ff <= 32'($signed(data_ff[0]));
				OFS_OUT_Y:     rdata_ff <= 32'($signed(data_ff[1]));
				OFS_OUT_Z:     rdata_ff <= 32'($signed(data_ff[2]));
				OFS_CTRL:      rdata_ff <= 32'(ctrl_ff);
				OFS_STATUS:    rdata_ff <= 32'({drdy_ff, 2'(mode_ff)});
				OFS_SMP_COUNT: rdata_ff <= 32'(smp_cnt_ff);
				default:       rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	assign bus_rdata      = rdata_ff;
	assign sense_en       = sense_ff;
	assign selftest_drive = st_ff;
	assign sample_tick    = tick_ff;
	assign op_mode        = mode_ff;

	a_no_clk_stretch: assert property (@(posedge mclk) disable iff (sys_rst)
		!scl_oe) else $error("clock line driven low by device");

	a_spike_reject: assert property (@(posedge mclk) disable iff (rst_all)
		$changed(scl_filt) |-> (scl_filt == $past(scl_in)) && (scl_filt == $past(scl_in, 2)))
		else $error("clock spike passed the filter");

	a_scale_4g: assert property (@(posedge mclk) disable iff (rst_all)
		(tick_ff && range == RANGE_4G && !ctrl_ff[CTRL_SELFT_BIT] && !act_entry
			&& accel_in[0] < 16'sh0800 && accel_in[0] > -16'sh0800)
		|=> data_ff[0] == 12'($past(accel_in[0]) >>> 1))
		else $error("four g scaling wrong");

	a_twos_sat: assert property (@(posedge mclk) disable iff (rst_all)
		(tick_ff && range == RANGE_2G && !ctrl_ff[CTRL_SELFT_BIT] && !act_entry
			&& accel_in[1] < -16'sh0800)
		|=> data_ff[1] == CODE_MIN) else $error("negative saturation wrong");

	a_selftest_sum: assert property (@(posedge mclk) disable iff (rst_all)
		(tick_ff && range == RANGE_2G && ctrl_ff[CTRL_SELFT_BIT] && !act_entry
			&& accel_in[2] == 16'sh0000)
		|=> data_ff[2] == 12'(ST_STIM)) else $error("self-test output not stimulus");

	a_off_silent: assert property (@(posedge mclk) disable iff (sys_rst)
		!power_good |=> (bus_rdata == 32'h0000_0000) && !sense_en && op_mode == MODE_OFF)
		else $error("device active while powered off");

	a_standby_quiet: assert property (@(posedge mclk) disable iff (rst_all)
		(mode_ff == MODE_STANDBY) [*2] |-> !sense_en && !sample_tick)
		else $error("sensing runs in standby");

	a_active_start: assert property (@(posedge mclk) disable iff (rst_all)
		(mode_ff == MODE_STANDBY && ctrl_ff[CTRL_ACTIVE_BIT]) |-> ##[1:2] sense_en)
		else $error("active mode did not start sensing");

	a_entry_clear: assert property (@(posedge mclk) disable iff (rst_all)
		act_entry |=> smp_cnt_ff == COUNT_RESET && !drdy_ff && data_ff[0] == DATA_RESET)
		else $error("registers not reset on activation");

	a_sleep_in_act: assert property (@(posedge mclk) disable iff (rst_all)
		(mode_ff == MODE_SLEEP) |-> $past(ctrl_ff[CTRL_ACTIVE_BIT]))
		else $error("sleep outside active mode");
endmodule
`default_nettype wire

// [test/i2c_host_model.sv]
// host side of the serial bus: open-drain drivers with pull-ups and a spike injector
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
	input  wire logic mclk,
	input  wire logic scl_out,
	input  wire logic scl_oe,
	output wire logic scl_in,
	output wire logic sda_in
);
	logic scl_low;
	logic sda_low;

	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// wired-and with pull-ups; the device pulling the clock low shows on the wire
	assign scl_in = !(scl_low || (scl_oe && !scl_out));
	assign sda_in = !sda_low;

	// hold one line low for a number of clock cycles, then release to the pull-up
	task automatic spike(input bit on_scl, input int cycles);
		@(posedge mclk);
		if (on_scl) scl_low <= 1'b1;
		else sda_low <= 1'b1;
		repeat (cycles) @(posedge mclk);
		scl_low <= 1'b0;
		sda_low <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking testbench for the accelerometer operating-mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
	import accel_mode_pkg::*;
	localparam logic signed [15:0] ST_VAL = 16'sh00c0;
	logic                mclk, sys_rst, power_good, bus_wr, bus_rd, motion_evt;
	logic [7:0]          bus_addr;
	logic [31:0]         bus_wdata, bus_rdata, d;
	logic signed [15:0]  accel_x, accel_y, accel_z;
	logic signed [15:0]  acc [3];
	wire logic           scl_in, sda_in, scl_out, scl_oe;
	logic                scl_filt, sda_filt, sense_en, selftest_drive, sample_tick, oe_seen, lo;
	op_mode_t            op_mode;
	int                  fails, comparisons, n, seed;

	accel_mode_ctrl #(.WAKE_DIV(8), .SLEEP_DIV(32), .SLEEP_SAMPLES(2), .ST_STIM(ST_VAL)) i_dut (
		.mclk(mclk), .sys_rst(sys_rst), .power_good(power_good), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.scl_in(scl_in), .sda_in(sda_in), .scl_filt(scl_filt), .sda_filt(sda_filt),
		.scl_out(scl_out), .scl_oe(scl_oe), .accel_x(accel_x), .accel_y(accel_y),
		.accel_z(accel_z), .motion_evt(motion_evt), .sense_en(sense_en),
		.selftest_drive(selftest_drive), .sample_tick(sample_tick), .op_mode(op_mode));
	i2c_host_model i_host (.mclk(mclk), .scl_out(scl_out), .scl_oe(scl_oe), .scl_in(scl_in),
		.sda_in(sda_in));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = !mclk;
	end
	// the clock-line enable is unknown until the first reset edge, so only watch after reset
	always @(posedge mclk) oe_seen <= sys_rst ? 1'b0 : (oe_seen | (scl_oe !== 1'b0));

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= v;
		@(posedge mclk);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge mclk);
		bus_rd <= 1'b0;
		#1 v = bus_rdata;
	endtask
	// configuration goes in while in standby, then the active bit follows
	task automatic set_mode(input logic [4:0] cfg);
		wr(OFS_CTRL, {27'h0, cfg & 5'h1e});
		wr(OFS_CTRL, {27'h0, cfg});
	endtask
	task automatic wait_tick();
		n = 0;
		while (sample_tick !== 1'b1 && n < 200) begin
			@(posedge mclk);
			#1 n++;
		end
		`CHECK(n < 200, 1'b1)
	endtask
	task automatic endt(input string s);
		$display("test %s finished", s);
	endtask
	task automatic test_done();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	function automatic logic [31:0] exp_code(logic signed [15:0] a, logic [1:0] r, logic st);
		logic signed [17:0] s;
		s = a;
		if (st) s = s + ST_VAL;
		if (r == RANGE_4G) s = s >>> 1;
		else if (r != RANGE_2G) s = s >>> 2;
		if (s > 18'sd2047) s = 18'sd2047;
		if (s < -18'sd2048) s = -18'sd2048;
		return {{20{s[11]}}, s[11:0]};
	endfunction

	initial begin
		#(50 * 20000);
		fails++;
		test_done();
	end

	initial begin
		seed = 32'h9808;
		{bus_wr, bus_rd, motion_evt, bus_addr, bus_wdata} = '0;
		{accel_x, accel_y, accel_z} = '0;
		sys_rst = 1'b1;
		power_good = 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		#1 `CHECK(op_mode, MODE_STANDBY)
		rd(OFS_CTRL, d);
		`CHECK(d, 32'h0000_0000)
		rd(8'h3c, d);
		`CHECK(d, 32'h0000_0000)
		n = 0;
		repeat (40) begin
			@(posedge mclk);
			#1 n += int'(sample_tick !== 1'b0);
		end
		`CHECK(n, 0)
		`CHECK(sense_en, 1'b0)
		endt("standby");
		for (int k = 0; k < 8; k++) begin
			for (int j = 0; j < 3; j++) acc[j] = $random(seed);
			if (k % 3 == 0) acc[0] = 16'sh7fff;
			if (k % 3 == 1) acc[0] = -16'sh8000;
			// corners that reach the saturation, self-test and four g checks
			if (k == 0) acc[1] = -16'sh7000;
			if (k == 1) acc[2] = 16'sh0000;
			if (k == 2) acc[0] = 16'sh0123;
			@(posedge mclk);
			accel_x <= acc[0];
			accel_y <= acc[1];
			accel_z <= acc[2];
			set_mode({1'b0, k[0], k[2:1], 1'b1});
			wait_tick();
			repeat (2) @(posedge mclk);
			#1 `CHECK(sense_en, 1'b1)
			`CHECK(op_mode, MODE_WAKE)
			`CHECK(selftest_drive, k[0])
			for (int j = 0; j < 3; j++) begin
				rd(OFS_OUT_X + 8'(4 * j), d);
				`CHECK(d, exp_code(acc[j], k[2:1], k[0]))
			end
			@(posedge mclk);
			#1 `CHECK(bus_rdata, 32'h0000_0000)
		end
		endt("scaling");
		wr(OFS_CTRL, 32'h0000_0000);
		rd(OFS_SMP_COUNT, d);
		`CHECK(d != 0, 1'b1)
		wr(OFS_CTRL, 32'h0000_0001);
		rd(OFS_SMP_COUNT, d);
		`CHECK(d, 32'h0000_0000)
		rd(OFS_OUT_X, d);
		`CHECK(d, 32'h0000_0000)
		endt("activation");
		set_mode(5'h11);
		n = 0;
		while (op_mode !== MODE_SLEEP && n < 300) begin
			@(posedge mclk);
			#1 n++;
		end
		`CHECK(op_mode, MODE_SLEEP)
		@(posedge mclk);
		motion_evt <= 1'b1;
		@(posedge mclk);
		motion_evt <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 `CHECK(op_mode, MODE_WAKE)
		wr(OFS_CTRL, 32'h0000_0010);
		repeat (3) @(posedge mclk);
		#1 `CHECK(op_mode, MODE_STANDBY)
		`CHECK(sense_en, 1'b0)
		endt("sleep");
		for (int w = 1; w < 4; w += 2) begin
			for (int ln = 0; ln < 2; ln++) begin
				fork
					i_host.spike(ln[0], w);
					begin
						lo = 1'b0;
						repeat (w + 5) begin
							@(posedge mclk);
							#1 lo |= !(ln ? scl_filt : sda_filt);
						end
					end
				join
				`CHECK(lo, w > 1)
			end
		end
		endt("spike filter");
		@(posedge mclk);
		power_good <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 `CHECK(op_mode, MODE_OFF)
		wr(OFS_CTRL, 32'h0000_0001);
		rd(OFS_CTRL, d);
		`CHECK(d, 32'h0000_0000)
		`CHECK(sense_en, 1'b0)
		@(posedge mclk);
		power_good <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 `CHECK(op_mode, MODE_STANDBY)
		rd(OFS_CTRL, d);
		`CHECK(d, 32'h0000_0000)
		`CHECK(oe_seen, 1'b0)
		`CHECK(scl_out, 1'b0)
		endt("power off");
		test_done();
	end
endmodule
`default_nettype wire
